// ---- spi_master_model.sv ----
// Behavioural SPI master for the register port
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    // Link pins
    output logic sclk_o,
    output logic ss_n_o,
    output logic d_o,
    output logic oe_o,
    // Data seen by the master
    input wire logic din_i
);
    // Deselected, clock parked
    initial begin
        sclk_o = 1'b0;
        ss_n_o = 1'b1;
        d_o = 1'b0;
        oe_o = 1'b0;
    end

    // One access of nb bits, 80 ns clock; rel frees the line after the command
    task automatic frame(input logic cpol, input logic rel, input int nb,
                         input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        sclk_o = cpol;
        #40;
        ss_n_o = 1'b0;
        oe_o = 1'b1;
        d_o = tx[63];
        #40;
        for (int i = 0; i < nb; i++) begin
            sclk_o = 1'b0;
            d_o = tx[63-i];
            if (rel && i == 8) oe_o = 1'b0;
            #40;
            sclk_o = 1'b1;
            rx[63-i] = din_i;
            #40;
        end
        sclk_o = cpol;
        #40;
        ss_n_o = 1'b1;
        oe_o = 1'b0;
    endtask : frame
endmodule : spi_master_model
`default_nettype wire

// ---- spi_slave_register_port.sv ----
// Package and top module of the SPI slave register access port
`timescale 1ns/1ps
`default_nettype none

package spi_port_pkg;
    localparam int BITS_PER_BYTE = 8;
    localparam int ADDR_W = 5;
    localparam int IDX_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;      // Eighth bit of a byte
    localparam logic [2:0] BIT_FIRST = 3'h0;     // Byte boundary
    localparam logic [2:0] BIT_ADDR_DONE = 3'h5; // Sixth bit: direction and address known
    localparam int CMD_DIR_POS = 4;              // Direction bit within the partial shift
    localparam logic CMD_IS_WRITE = 1'b1;        // Direction value for a write
    localparam logic FDX_RESET = 1'b0;           // Half duplex after power-on
    localparam logic [IDX_W-1:0] IDX_ONE = 8'h01;
    localparam int CMD_DIR_BIT = 7;              // Direction bit of the command byte
    localparam int CMD_ADDR_HI = 6;              // Top address bit of the command byte
    localparam int CMD_ADDR_LO = 2;              // Bottom address bit of the command byte
    localparam int SHIFT_TOP = 6;                // Top bit of the partial shift
    localparam int BYTE_MSB = 7;                 // First bit out of every byte

    // Write event passed from link to core
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [IDX_W-1:0] idx;
        logic [BITS_PER_BYTE-1:0] data;
    } wr_word_t;

    // Read request passed from link to core
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [IDX_W-1:0] idx;
    } rd_word_t;
endpackage : spi_port_pkg

module spi_slave_register_port (
    // Core clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // SPI pins
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    output logic miso_o,
    output logic miso_oe_o,
    // Mode bit written by the register block
    input wire logic fdx_wr_i,
    input wire logic fdx_val_i,
    output logic full_duplex_select_o,
    // Status byte returned on miso during the command byte, in full duplex only
    input wire logic [7:0] status_i,
    // Register write port
    output logic wr_valid_o,
    output spi_port_pkg::wr_word_t wr_word_o,
    // Register read port, data taken one cycle after the request
    output logic rd_req_o,
    output spi_port_pkg::rd_word_t rd_word_o,
    input wire logic [7:0] rd_data_i
);

    // Link domain reset: held while deselected or in power-on reset
    logic link_rst_n;
    assign link_rst_n = rst_n_i & ~ss_n_i;

    // Core-side hold registers read quasi-statically by the link
    logic fdx_q;
    logic fdx_hold_q;
    logic [7:0] status_hold_q;
    logic [7:0] rd_hold_q;

    // Link rising-edge state
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic cmd_done_q;
    logic write_q;
    logic [spi_port_pkg::ADDR_W-1:0] addr_q;
    logic [spi_port_pkg::IDX_W-1:0] idx_q;
    logic wr_tgl_q;
    spi_port_pkg::wr_word_t wr_link_q;
    logic rd_tgl_q;
    spi_port_pkg::rd_word_t rd_link_q;
    logic rise_seen_q;

    // Link falling-edge state
    logic [7:0] tx_q;
    logic neg_seen_q;
    logic drive_q;

    // Command direction: set for a write, clear for a read
    function automatic logic cmd_is_write(input logic dir);
        return dir == spi_port_pkg::CMD_IS_WRITE;
    endfunction : cmd_is_write

    // Last bit of a byte arrives on this rising edge
    function automatic logic byte_ends(input logic [2:0] cnt);
        return cnt == spi_port_pkg::BIT_LAST;
    endfunction : byte_ends

    // Bytes after the command carry read data, and drive the shared line, only for a read
    function automatic logic reading(input logic done, input logic wr);
        return done && !wr;
    endfunction : reading

    // A toggle that differs from its last seen copy marks a new event
    function automatic logic tgl_event(input logic cur, input logic seen);
        return cur != seen;
    endfunction : tgl_event

    logic [7:0] rx_byte;
    assign rx_byte = {shift_q, mosi_i};

    // Bit counter on rising edges
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= spi_port_pkg::BIT_FIRST;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // Input shifter, newest bit at the bottom
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift_q <= '0;
        end else begin
            shift_q <= rx_byte[spi_port_pkg::SHIFT_TOP:0];
        end
    end

    // First rising edge seen; a mode (1,1) access opens with a bare falling edge
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rise_seen_q <= 1'b0;
        end else begin
            rise_seen_q <= 1'b1;
        end
    end

    // Command byte decode
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cmd_done_q <= 1'b0;
            write_q <= 1'b0;
            addr_q <= '0;
        end else if (!cmd_done_q && byte_ends(bit_cnt_q)) begin
            cmd_done_q <= 1'b1;
            write_q <= cmd_is_write(rx_byte[spi_port_pkg::CMD_DIR_BIT]);
            addr_q <= rx_byte[spi_port_pkg::CMD_ADDR_HI:spi_port_pkg::CMD_ADDR_LO];
        end
    end

    // Byte index within the burst, restarted by every deselect
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            idx_q <= '0;
        end else if (cmd_done_q && byte_ends(bit_cnt_q)) begin
            idx_q <= idx_q + spi_port_pkg::IDX_ONE;
        end
    end

    // Completed data bytes of a write become write events; the toggle
    // survives deselect so that a frame end never looks like an event
    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_tgl_q <= 1'b0;
            wr_link_q <= '0;
        end else if (cmd_done_q && write_q && byte_ends(bit_cnt_q)) begin
            wr_link_q <= '{addr: addr_q, idx: idx_q, data: rx_byte};
            wr_tgl_q <= ~wr_tgl_q;
        end
    end

    // Read prefetch: first byte once the address is known, then one byte ahead;
    // like the write toggle it is cleared only by power-on reset
    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_tgl_q <= 1'b0;
            rd_link_q <= '0;
        end else if (!cmd_done_q && bit_cnt_q == spi_port_pkg::BIT_ADDR_DONE) begin
            if (!cmd_is_write(shift_q[spi_port_pkg::CMD_DIR_POS])) begin
                rd_link_q <= '{addr: rx_byte[spi_port_pkg::ADDR_W-1:0], idx: '0};
                rd_tgl_q <= ~rd_tgl_q;
            end
        end else if (reading(cmd_done_q, write_q) && bit_cnt_q == spi_port_pkg::BIT_FIRST) begin
            rd_link_q <= '{addr: addr_q, idx: idx_q + spi_port_pkg::IDX_ONE};
            rd_tgl_q <= ~rd_tgl_q;
        end
    end

    // Falling edges count only after a rising edge: a mode (1,1) access
    // opens with a falling edge that must not move the first bit
    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            neg_seen_q <= 1'b0;
        end else if (rise_seen_q) begin
            neg_seen_q <= 1'b1;
        end
    end

    // Shared line driver turns on after the command of a read
    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            drive_q <= 1'b0;
        end else if (rise_seen_q) begin
            drive_q <= reading(cmd_done_q, write_q);
        end
    end

    // Output shifter on falling edges
    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_q <= '0;
        end else if (!rise_seen_q) begin
            tx_q <= '0; // Bare opening edge of mode (1,1)
        end else if (!neg_seen_q) begin
            tx_q <= {status_hold_q[spi_port_pkg::SHIFT_TOP:0], 1'b0};
        end else if (bit_cnt_q == spi_port_pkg::BIT_FIRST) begin
            tx_q <= reading(cmd_done_q, write_q) ? rd_hold_q : 8'h00;
        end else begin
            tx_q <= {tx_q[spi_port_pkg::SHIFT_TOP:0], 1'b0};
        end
    end

    // Pin drive: first status bit shown on miso before any clock edge in full duplex
    logic out_bit;
    assign out_bit = neg_seen_q ? tx_q[spi_port_pkg::BYTE_MSB]
                                : status_hold_q[spi_port_pkg::BYTE_MSB];
    assign miso_o = out_bit;
    assign miso_oe_o = fdx_hold_q & ~ss_n_i;
    assign mosi_o = out_bit;
    assign mosi_oe_o = ~fdx_hold_q & ~ss_n_i & drive_q;

    // Core domain synchronisers
    logic ss_n_s;
    logic wr_tgl_s;
    logic rd_tgl_s;
    logic wr_tgl_seen_q;
    logic rd_tgl_seen_q;
    logic rd_pend_q;

    spi_sync2 #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({ss_n_i, wr_tgl_q, rd_tgl_q}),
        .q_o({ss_n_s, wr_tgl_s, rd_tgl_s})
    );

    // Mode bit, loaded by the write strobe; power-on reset clears it, deselect does not
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fdx_q <= spi_port_pkg::FDX_RESET;
        end else if (fdx_wr_i) begin
            fdx_q <= fdx_val_i;
        end
    end
    assign full_duplex_select_o = fdx_q;

    // Mode frozen while an access is in progress
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fdx_hold_q <= spi_port_pkg::FDX_RESET;
        end else if (ss_n_s) begin
            fdx_hold_q <= fdx_q;
        end
    end

    // Status frozen from just after select; it must be steady before select falls
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_hold_q <= '0;
        end else if (ss_n_s) begin
            status_hold_q <= status_i;
        end
    end

    // Write event delivery
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_tgl_seen_q <= 1'b0;
            wr_valid_o <= 1'b0;
        end else begin
            wr_tgl_seen_q <= wr_tgl_s;
            wr_valid_o <= tgl_event(wr_tgl_s, wr_tgl_seen_q);
        end
    end

    // Write word taken from the link once its toggle has settled
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_word_o <= '0;
        end else if (tgl_event(wr_tgl_s, wr_tgl_seen_q)) begin
            wr_word_o <= wr_link_q;
        end
    end

    // Read request pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_tgl_seen_q <= 1'b0;
            rd_req_o <= 1'b0;
        end else begin
            rd_tgl_seen_q <= rd_tgl_s;
            rd_req_o <= tgl_event(rd_tgl_s, rd_tgl_seen_q);
        end
    end

    // Read word taken from the link once its toggle has settled
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_word_o <= '0;
        end else if (tgl_event(rd_tgl_s, rd_tgl_seen_q)) begin
            rd_word_o <= rd_link_q;
        end
    end

    // Read data captured one cycle after the request; the link reads it at a
    // byte boundary, long after it has settled
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend_q <= 1'b0;
            rd_hold_q <= '0;
        end else begin
            rd_pend_q <= rd_req_o;
            if (rd_pend_q) begin
                rd_hold_q <= rd_data_i;
            end
        end
    end

endmodule : spi_slave_register_port

`default_nettype wire

// ---- spi_slave_register_port_bench.sv ----
// Self-checking bench for the SPI register port
`timescale 1ns/1ps
`default_nettype none
module spi_slave_register_port_bench;
    logic clk_i, rst_n_i, sclk_i, ss_n_i, mosi_i, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    logic fdx_wr_i, fdx_val_i, full_duplex_select_o, wr_valid_o, rd_req_o, m_d, m_oe, din;
    logic [7:0] status_i, rd_data_i;
    logic [63:0] rx;
    logic fdx = 1'b0;
    spi_port_pkg::wr_word_t wr_word_o;
    spi_port_pkg::rd_word_t rd_word_o;
    spi_port_pkg::wr_word_t wq[$];
    int num_errors = 0, compares = 0, cycles = 0;
    `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
        $display("wrong value %s exp %h got %h", n, e, s); end end

    // Released lines toggle instead of holding their last value
    assign mosi_i = m_oe ? m_d : (mosi_oe_o ? mosi_o : clk_i);
    assign din = fdx ? (miso_oe_o ? miso_o : clk_i) : mosi_i;

    spi_slave_register_port dut (.clk_i, .rst_n_i, .sclk_i, .ss_n_i, .mosi_i, .mosi_o,
        .mosi_oe_o, .miso_o, .miso_oe_o, .fdx_wr_i, .fdx_val_i, .full_duplex_select_o,
        .status_i, .wr_valid_o, .wr_word_o, .rd_req_o, .rd_word_o, .rd_data_i);
    spi_master_model master (.sclk_o(sclk_i), .ss_n_o(ss_n_i), .d_o(m_d), .oe_o(m_oe),
        .din_i(din));

    // Register contents seen through the read port
    function automatic logic [7:0] rdv(logic [4:0] a, logic [7:0] i);
        return {a[3:0], i[3:0]} ^ 8'hA5;
    endfunction : rdv

    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    // Mode change through the strobe, then settle
    task automatic set_mode(input logic v);
        @(posedge clk_i) #1;
        fdx_wr_i = 1'b1;
        fdx_val_i = v;
        @(posedge clk_i) #1;
        fdx_wr_i = 1'b0;
        fdx = v;
        repeat (8) @(posedge clk_i) #1;
        status_i = 8'h5A ^ {8{v}};
        `CHK("mode", v, full_duplex_select_o)
        wq.delete();
    endtask : set_mode

    task automatic t_fdx_read(input logic cpol);
        master.frame(cpol, 1'b0, 24, {8'h28, 16'hFFFF, 40'h0}, rx);
        `CHK("status", status_i, rx[63:56])
        `CHK("rd0", rdv(5'h0A, 8'h00), rx[55:48])
        `CHK("rd1", rdv(5'h0A, 8'h01), rx[47:40])
    endtask : t_fdx_read

    task automatic t_fdx_write();
        master.frame(1'b0, 1'b0, 35, {8'hC4, 8'h3C, 8'hC3, 8'h5A, 8'hE0, 24'h0}, rx);
        repeat (8) @(posedge clk_i);
        `CHK("zeros", 24'h0, rx[55:32])
        `CHK("count", 3, wq.size())
        `CHK("w0", {5'h11, 8'h00, 8'h3C}, wq[0])
        `CHK("w1", {5'h11, 8'h01, 8'hC3}, wq[1])
        `CHK("w2", {5'h11, 8'h02, 8'h5A}, wq[2])
        wq.delete();
        master.frame(1'b1, 1'b0, 8, {8'hC4, 56'h0}, rx);
        repeat (8) @(posedge clk_i);
        `CHK("cmd only", status_i, rx[63:56])
        `CHK("no write", 0, wq.size())
    endtask : t_fdx_write

    task automatic t_hdx_read();
        master.frame(1'b0, 1'b1, 16, {8'h50, 56'h0}, rx);
        `CHK("half rd", rdv(5'h14, 8'h00), rx[55:48])
        `CHK("miso off", 1'b0, miso_oe_o)
    endtask : t_hdx_read

    // Core clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Read data source, write log and hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (rd_req_o) rd_data_i <= #1 rdv(rd_word_o.addr, rd_word_o.idx);
        if (wr_valid_o) wq.push_back(wr_word_o);
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        fdx_wr_i = 1'b0;
        fdx_val_i = 1'b0;
        status_i = 8'h00;
        rd_data_i = 8'h00;
        repeat (8) @(posedge clk_i) #1;
        rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i) #1;
        `CHK("reset mode", 1'b0, full_duplex_select_o)
        `CHK("reset oe", 1'b0, miso_oe_o)
        set_mode(1'b1);
        t_fdx_read(1'b0);
        t_fdx_read(1'b1);
        t_fdx_write();
        set_mode(1'b0);
        t_hdx_read();
        test_done();
    end
endmodule : spi_slave_register_port_bench

bind spi_slave_register_port spi_slave_register_port_checker chk (.clk_i, .rst_n_i, .ss_n_i,
    .miso_oe_o, .mosi_oe_o, .fdx_wr_i, .fdx_val_i, .full_duplex_select_o, .wr_valid_o,
    .wr_word_o, .rd_req_o, .rd_word_o);
`default_nettype wire

// ---- spi_slave_register_port_checker.sv ----
// Pin-level assertions for the SPI register port
`timescale 1ns/1ps
`default_nettype none
module spi_slave_register_port_checker (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Watched pins
    input wire logic ss_n_i,
    input wire logic miso_oe_o,
    input wire logic mosi_oe_o,
    input wire logic fdx_wr_i,
    input wire logic fdx_val_i,
    input wire logic full_duplex_select_o,
    input wire logic wr_valid_o,
    input wire spi_port_pkg::wr_word_t wr_word_o,
    input wire logic rd_req_o,
    input wire spi_port_pkg::rd_word_t rd_word_o
);
    // All checks run on the core clock
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_miso_sel_only: assert property (miso_oe_o |-> !ss_n_i && full_duplex_select_o)
        else $error("miso driven off");
    a_shared_half: assert property (mosi_oe_o |-> !ss_n_i && !miso_oe_o)
        else $error("shared line misdriven");
    a_mode_load: assert property (fdx_wr_i |=> full_duplex_select_o == $past(fdx_val_i))
        else $error("mode not loaded");
    a_mode_hold: assert property (!fdx_wr_i |=> $stable(full_duplex_select_o))
        else $error("mode moved");
    a_wr_pulse: assert property (wr_valid_o |=> !wr_valid_o)
        else $error("write pulse long");
    a_rd_pulse: assert property (rd_req_o |=> !rd_req_o)
        else $error("read pulse long");
    a_wr_word_hold: assert property (!wr_valid_o |-> $stable(wr_word_o))
        else $error("write word moved");
    a_rd_word_hold: assert property (!rd_req_o |-> $stable(rd_word_o))
        else $error("read word moved");
    a_idle_quiet: assert property (ss_n_i [*8] |-> !wr_valid_o && !rd_req_o)
        else $error("activity while idle");
endmodule : spi_slave_register_port_checker
`default_nettype wire

// ---- spi_sync2.sv ----
// Two-flop level synchroniser into the destination clock domain
`timescale 1ns/1ps
`default_nettype none

module spi_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Destination clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Asynchronous level in, synchronised level out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;

    // First flop feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RESET_VAL;
            q_o <= RESET_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule : spi_sync2

`default_nettype wire
